//--- design/irq_mask_bank_params.svh
/*
 * Offsets, field positions, reset values and sizes of the pin and start-up
 * interrupt mask bank. Included by the package and the mask bank module.
 */
`ifndef IRQ_MASK_BANK_PARAMS_SVH
`define IRQ_MASK_BANK_PARAMS_SVH

// Register offsets on the register port
`define OFS_PIN1_8_FALL_IRQ_MASK 8'h4f
`define OFS_PIN1_8_RISE_IRQ_MASK 8'h50
`define OFS_PIN9_10_EDGE_IRQ_MASK 8'h51
`define OFS_STARTUP_EVENT_IRQ_MASK 8'h52

// Reset value of every mask register
`define MASK_RESET_VALUE 8'h00

// Fields of the pin 9/10 register
`define POS_PIN10_HIGH_EDGE_BLOCK 4
`define POS_PIN9_HIGH_EDGE_BLOCK 3
`define POS_PIN10_LOW_EDGE_BLOCK 1
`define POS_PIN9_LOW_EDGE_BLOCK 0
`define PIN9_10_WRITABLE 8'h1b

// Fields of the start-up register
`define POS_WARM_RESTART_EVENT_BLOCK 5
`define POS_FIRST_SUPPLY_EVENT_BLOCK 4
`define POS_ENABLE_EVENT_BLOCK 1
`define STARTUP_WRITABLE 8'h32

// Sizes
`define PIN_COUNT 10
`define EVENT_COUNT 23

// Positions in the event vector
`define EVT_FALL_BASE 0
`define EVT_RISE_BASE 10
`define EVT_WARM_RESTART 20
`define EVT_FIRST_SUPPLY 21
`define EVT_ENABLE 22

`endif

//--- design/irq_mask_bank_pkg.sv
/*
 * Types shared by the mask bank modules.
 * Assumes irq_mask_bank_params.svh is on the include path.
 */
`include "irq_mask_bank_params.svh"

package irq_mask_bank_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [`PIN_COUNT-1:0] pin_vec_t;
    typedef logic [`EVENT_COUNT-1:0] event_vec_t;
endpackage : irq_mask_bank_pkg

//--- design/pin_edge_detect.sv
/*
 * Two-stage synchroniser and edge detector for the general-purpose pins.
 * Assumes asynchronous pin levels and one clock with a clock enable.
 */
`timescale 1ns/1ps

module pin_edge_detect
    import irq_mask_bank_pkg::*;
(
    input wire logic i_clk, // Core clock
    input wire logic i_resetn, // Async reset, active low
    input wire logic i_ce, // Clock enable
    input wire pin_vec_t i_pin, // Raw pin levels
    output pin_vec_t o_level, // Synchronised levels
    output pin_vec_t o_fall, // High-to-low pulse
    output pin_vec_t o_rise // Low-to-high pulse
);
    pin_vec_t meta_reg;
    pin_vec_t sync_reg;
    pin_vec_t last_reg;
    pin_vec_t meta_next;
    pin_vec_t sync_next;
    pin_vec_t last_next;

    // Next values: meta only feeds sync
    always_comb begin
        meta_next = i_pin;
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    // Registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else if (i_ce) begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    // Edge pulses from settled samples
    assign o_level = sync_reg;
    assign o_fall = last_reg & ~sync_reg;
    assign o_rise = ~last_reg & sync_reg;
endmodule : pin_edge_detect

//--- design/gpio_startup_irq_mask_bank.sv
/*
 * Interrupt mask bank for ten pins (both edges) and three start-up events.
 * Holds four mask registers on a simple register port, pending flags for
 * every event, the live pin levels and one combined interrupt request.
 * Assumes a serial-interface front end drives the register port on i_clk,
 * and a defaults loader pulses i_nvm_load with values from the store.
 * Reserved bits ignore writes and read zero; unmapped offsets read zero.
 * A defaults load beats a host write in the same cycle.
 * Masked events still latch, so opening a mask raises the request at once.
 * A pin already high when reset ends reports one rising edge.
 * Pins pass two flops before any logic; events and clears are on i_clk.
 * Clock enable low freezes every flop, the synchroniser included.
 */
// Behaviour
// - Register 0x4f bit n-1 blocks the falling-edge interrupt of pin n, pins 1-8.
// - Register 0x50 bit n-1 blocks the rising-edge interrupt of pin n, pins 1-8.
// - Register 0x51 holds pin 10/9 rising at bits 4/3, falling at 1/0.
// - Mask bit 0 lets its interrupt through; 1 suppresses it.
// - Live pin levels update whatever the masks hold.
// - Register 0x52 bit 5 blocks the warm-restart event interrupt.
// - Register 0x52 bit 4 blocks first-supply event; bits 7:6, 3:2 reserved.
// - Register 0x52 bit 1 blocks the enable event; bit 0 reserved.
// - Every mask bit takes its default from the non-volatile store.
// - Four eight-bit read-write registers, reading 0x00 after reset.
`timescale 1ns/1ps
`include "irq_mask_bank_params.svh"

module gpio_startup_irq_mask_bank
    import irq_mask_bank_pkg::*;
(
    input wire logic i_clk, // 250 MHz core clock
    input wire logic i_resetn, // Async reset, active low
    input wire logic i_ce, // Clock enable, freezes state when low
    input wire logic [7:0] i_reg_addr, // Register offset
    input wire logic i_reg_wr, // Write strobe
    input wire logic i_reg_rd, // Read strobe
    input wire reg_byte_t i_reg_wdata, // Write data
    output reg_byte_t o_reg_rdata, // Read data, one cycle after strobe
    output logic o_reg_rvalid, // Read data valid pulse
    input wire logic i_nvm_load, // Load defaults pulse
    input wire reg_byte_t i_nvm_fall_def, // Default for 0x4f
    input wire reg_byte_t i_nvm_rise_def, // Default for 0x50
    input wire reg_byte_t i_nvm_pin9_10_def, // Default for 0x51
    input wire reg_byte_t i_nvm_startup_def, // Default for 0x52
    input wire pin_vec_t i_pin, // Raw pin levels, asynchronous
    input wire logic i_warm_restart_evt, // Warm-restart event pulse
    input wire logic i_first_supply_evt, // First-supply event pulse
    input wire logic i_enable_evt, // Enable event pulse
    input wire event_vec_t i_flag_clear, // Clear pulses for pending flags
    output pin_vec_t o_pin_level, // Live pin level bits
    output event_vec_t o_event_flag, // Pending event flags
    output logic o_irq_req // Combined request, active high
);
    // Mask registers and their next values
    reg_byte_t fall_mask_reg;
    reg_byte_t rise_mask_reg;
    reg_byte_t pin9_10_mask_reg;
    reg_byte_t startup_mask_reg;
    reg_byte_t fall_mask_next;
    reg_byte_t rise_mask_next;
    reg_byte_t pin9_10_mask_next;
    reg_byte_t startup_mask_next;
    // Pending flags and read port
    event_vec_t flag_reg;
    event_vec_t flag_next;
    reg_byte_t rdata_reg;
    reg_byte_t rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    // Pin and event paths
    pin_vec_t pin_level;
    pin_vec_t pin_fall;
    pin_vec_t pin_rise;
    event_vec_t event_set;
    event_vec_t event_block;
    event_vec_t event_live;

    // Gathers all mask bits into event order
    function automatic event_vec_t block_vector(
        input reg_byte_t fall,
        input reg_byte_t rise,
        input reg_byte_t p910,
        input reg_byte_t startup
    );
        event_vec_t v;
        v = '0;
        v[`EVT_FALL_BASE +: 8] = fall;
        v[`EVT_RISE_BASE +: 8] = rise;
        v[`EVT_FALL_BASE + 8] = p910[`POS_PIN9_LOW_EDGE_BLOCK];
        v[`EVT_FALL_BASE + 9] = p910[`POS_PIN10_LOW_EDGE_BLOCK];
        v[`EVT_RISE_BASE + 8] = p910[`POS_PIN9_HIGH_EDGE_BLOCK];
        v[`EVT_RISE_BASE + 9] = p910[`POS_PIN10_HIGH_EDGE_BLOCK];
        v[`EVT_WARM_RESTART] = startup[`POS_WARM_RESTART_EVENT_BLOCK];
        v[`EVT_FIRST_SUPPLY] = startup[`POS_FIRST_SUPPLY_EVENT_BLOCK];
        v[`EVT_ENABLE] = startup[`POS_ENABLE_EVENT_BLOCK];
        return v;
    endfunction : block_vector

    // Maps an offset to the index of its mask register; 3'h4 means unmapped
    function automatic logic [2:0] reg_slot(input logic [7:0] addr);
        logic [2:0] slot;
        case (addr)
            `OFS_PIN1_8_FALL_IRQ_MASK: slot = 3'h0;
            `OFS_PIN1_8_RISE_IRQ_MASK: slot = 3'h1;
            `OFS_PIN9_10_EDGE_IRQ_MASK: slot = 3'h2;
            `OFS_STARTUP_EVENT_IRQ_MASK: slot = 3'h3;
            default: slot = 3'h4;
        endcase
        return slot;
    endfunction : reg_slot

    // Pin synchroniser and edge detector
    // Masks never gate the level path, so live status stays true
    pin_edge_detect u_pin_edge (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_pin(i_pin),
        .o_level(pin_level),
        .o_fall(pin_fall),
        .o_rise(pin_rise)
    );

    // Event sources in vector order
    assign event_set = {i_enable_evt, i_first_supply_evt, i_warm_restart_evt,
                        pin_rise, pin_fall};
    assign event_block = block_vector(fall_mask_reg, rise_mask_reg,
                                      pin9_10_mask_reg, startup_mask_reg);

    // Mask register next values: defaults load, then host writes
    // Reserved bits are cut so they read back as zero
    always_comb begin
        fall_mask_next = fall_mask_reg;
        rise_mask_next = rise_mask_reg;
        pin9_10_mask_next = pin9_10_mask_reg;
        startup_mask_next = startup_mask_reg;
        if (i_nvm_load) begin
            fall_mask_next = i_nvm_fall_def;
            rise_mask_next = i_nvm_rise_def;
            pin9_10_mask_next = i_nvm_pin9_10_def & `PIN9_10_WRITABLE;
            startup_mask_next = i_nvm_startup_def & `STARTUP_WRITABLE;
        end else if (i_reg_wr) begin
            case (reg_slot(i_reg_addr))
                3'h0: begin
                    fall_mask_next = i_reg_wdata;
                end
                3'h1: begin
                    rise_mask_next = i_reg_wdata;
                end
                3'h2: begin
                    pin9_10_mask_next = i_reg_wdata & `PIN9_10_WRITABLE;
                end
                3'h3: begin
                    startup_mask_next = i_reg_wdata & `STARTUP_WRITABLE;
                end
                default: begin
                    fall_mask_next = fall_mask_reg;
                end
            endcase
        end
    end

    // Mask registers; reset gives zero and the store's
    // defaults follow through the load pulse
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fall_mask_reg <= `MASK_RESET_VALUE;
            rise_mask_reg <= `MASK_RESET_VALUE;
            pin9_10_mask_reg <= `MASK_RESET_VALUE;
            startup_mask_reg <= `MASK_RESET_VALUE;
        end else if (i_ce) begin
            fall_mask_reg <= fall_mask_next;
            rise_mask_reg <= rise_mask_next;
            pin9_10_mask_reg <= pin9_10_mask_next;
            startup_mask_reg <= startup_mask_next;
        end
    end

    // Pending flags: set wins over clear, so an event that meets its own
    // clear is never lost; masks do not stop latching, which keeps the
    // flag visible to a host that polls with the request blocked
    always_comb begin
        flag_next = (flag_reg & ~i_flag_clear) | event_set;
    end

    // Read path: registered data for any offset
    // Unmapped offsets answer with zero and still pulse valid
    always_comb begin
        rvalid_next = i_reg_rd;
        rdata_next = rdata_reg;
        if (i_reg_rd) begin
            case (reg_slot(i_reg_addr))
                3'h0: rdata_next = fall_mask_reg;
                3'h1: rdata_next = rise_mask_reg;
                3'h2: rdata_next = pin9_10_mask_reg;
                3'h3: rdata_next = startup_mask_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Flags and read registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flag_reg <= '0;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else if (i_ce) begin
            flag_reg <= flag_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // Outputs
    assign o_pin_level = pin_level;
    assign o_event_flag = flag_reg;
    // Pending and unblocked: only these may raise the request
    assign event_live = flag_reg & ~event_block;
    assign o_irq_req = |event_live;
    assign o_reg_rdata = rdata_reg;
    assign o_reg_rvalid = rvalid_reg;
endmodule : gpio_startup_irq_mask_bank

//--- test/irq_mask_bank_monitor.sv
/* Port assertions for the mask bank.
   Bound to the top module; one clock, async low reset. */
`timescale 1ns/1ps
module irq_mask_bank_monitor
    import irq_mask_bank_pkg::*;
(
    input wire logic i_clk, // Clock
    input wire logic i_resetn, // Reset
    input wire logic i_ce, // Enable
    input wire logic [7:0] i_reg_addr, // Offset
    input wire logic i_reg_rd, // Read
    input wire reg_byte_t o_reg_rdata, // Data
    input wire logic o_reg_rvalid, // Valid
    input wire logic i_warm_restart_evt, // Event
    input wire logic i_first_supply_evt, // Event
    input wire logic i_enable_evt, // Event
    input wire event_vec_t i_flag_clear, // Clears
    input wire event_vec_t o_event_flag, // Flags
    input wire logic o_irq_req // Request
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    // Read answers and reserved bits
    read_answer_a: assert property (i_ce && i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    read_quiet_a: assert property (i_ce && !i_reg_rd |=> !o_reg_rvalid)
        else $error("answer without read");
    pin_reserved_a: assert property (o_reg_rvalid && $past(i_reg_addr) == 8'h51
        |-> (o_reg_rdata & 8'he4) == 8'h00) else $error("reserved bit set");
    start_reserved_a: assert property (o_reg_rvalid && $past(i_reg_addr) == 8'h52
        |-> (o_reg_rdata & 8'hcd) == 8'h00) else $error("reserved bit set");
    unmapped_zero_a: assert property (o_reg_rvalid && $past(i_reg_addr) == 8'h53
        |-> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    // Request, flag latching
    irq_cause_a: assert property (o_irq_req |-> o_event_flag != '0)
        else $error("request without flag");
    flag_sticky_a: assert property (i_ce |=>
        ($past(o_event_flag) & ~$past(i_flag_clear) & ~o_event_flag) == '0)
        else $error("flag lost");
    event_latch_a: assert property (i_ce |=> (~o_event_flag[22:20] &
        $past({i_enable_evt, i_first_supply_evt, i_warm_restart_evt})) == 3'h0)
        else $error("event not latched");
    cover property (o_irq_req);
    cover property (o_reg_rvalid && o_reg_rdata == 8'h32);
    cover property (o_event_flag == 23'h7fffff);
endmodule : irq_mask_bank_monitor

bind gpio_startup_irq_mask_bank irq_mask_bank_monitor i_mon (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_ce(i_ce), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_warm_restart_evt(i_warm_restart_evt), .i_first_supply_evt(i_first_supply_evt),
    .i_enable_evt(i_enable_evt), .i_flag_clear(i_flag_clear),
    .o_event_flag(o_event_flag), .o_irq_req(o_irq_req));

//--- test/reg_host_model.sv
/* Host side of the register port: single-byte writes and reads.
   Assumes the bank answers a read one edge after the strobe. */
`timescale 1ns/1ps
module reg_host_model
    import irq_mask_bank_pkg::*;
(
    input wire logic i_clk, // Clock
    input wire reg_byte_t i_rdata, // Read data
    input wire logic i_rvalid, // Read valid
    output logic [7:0] o_addr = 8'h00, // Offset
    output logic o_wr = 1'b0, // Write strobe
    output logic o_rd = 1'b0, // Read strobe
    output reg_byte_t o_wdata = 8'h00 // Write data
);
    // One strobe cycle, released lines inverted
    task automatic wr_reg(input logic [7:0] a, input reg_byte_t d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output reg_byte_t d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_clk);
        #1;
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rvalid ? i_rdata : 8'hxx;
    endtask : rd_reg
endmodule : reg_host_model

//--- test/tb.sv
/* Self-checking bench for the mask bank.
   Register traffic goes through the host model; one clock. */
`timescale 1ns/1ps
module tb;
    import irq_mask_bank_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic rvalid;
    logic irq;
    logic load = 1'b0;
    logic ce = 1'b1;
    logic [2:0] evt = 3'h0;
    reg_byte_t wdata;
    reg_byte_t rdata;
    reg_byte_t def [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    pin_vec_t pin = 10'h000;
    pin_vec_t level;
    event_vec_t clr = '0;
    event_vec_t flag;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    // Core clock, 4 ns
    always #2 i_clk = ~i_clk;
    reg_host_model i_host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
        .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
    gpio_startup_irq_mask_bank i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_nvm_load(load),
        .i_nvm_fall_def(def[0]), .i_nvm_rise_def(def[1]), .i_nvm_pin9_10_def(def[2]),
        .i_nvm_startup_def(def[3]), .i_pin(pin), .i_warm_restart_evt(evt[0]),
        .i_first_supply_evt(evt[1]), .i_enable_evt(evt[2]), .i_flag_clear(clr),
        .o_pin_level(level), .o_event_flag(flag), .o_irq_req(irq));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [22:0] got, input logic [22:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic rd_chk(input logic [7:0] a, input reg_byte_t exp);
        reg_byte_t d;
        i_host.rd_reg(a, d);
        check(23'(d), 23'(exp));
    endtask : rd_chk
    // Writable bits of each mask register
    function automatic reg_byte_t full(input logic [7:0] a);
        return (a == 8'h51) ? 8'h1b : (a == 8'h52) ? 8'h32 : (a == 8'h53) ? 8'h00 : 8'hff;
    endfunction : full
    // Offset and bit of each event's mask
    function automatic logic [10:0] ev_loc(input int e);
        if (e < 8) return {8'h4f, 3'(e)};
        if (e < 10) return {8'h51, 3'(e - 8)};
        if (e < 18) return {8'h50, 3'(e - 10)};
        if (e < 20) return {8'h51, 3'(e - 15)};
        return {8'h52, e == 20 ? 3'd5 : e == 21 ? 3'd4 : 3'd1};
    endfunction : ev_loc
    // Main sequence
    initial begin
        logic [10:0] loc;
        tick(16);
        i_resetn = 1'b1;
        for (int a = 8'h4f; a <= 8'h53; a++) begin
            rd_chk(8'(a), 8'h00);
            i_host.wr_reg(8'(a), 8'hff);
            rd_chk(8'(a), full(8'(a)));
        end
        def = '{8'ha5, 8'h5a, 8'hff, 8'hff};
        load = 1'b1;
        tick(1);
        load = 1'b0;
        for (int a = 8'h4f; a <= 8'h52; a++) begin
            rd_chk(8'(a), a < 8'h51 ? def[a - 8'h4f] : full(8'(a)));
            i_host.wr_reg(8'(a), full(8'(a)));
        end
        // Clock enable low: a write and an event pulse are both ignored
        ce = 1'b0;
        i_host.wr_reg(8'h4f, 8'h00);
        evt = 3'h1;
        tick(1);
        evt = 3'h0;
        ce = 1'b1;
        check(flag, 23'h0);
        rd_chk(8'h4f, 8'hff);
        // Both edges on every pin and all events, all blocked
        pin = 10'h3ff;
        tick(4);
        check(23'(level), 23'h3ff);
        pin = 10'h000;
        evt = 3'h7;
        tick(1);
        evt = 3'h0;
        tick(4);
        check(23'(level), 23'h0);
        check(flag, 23'h7fffff);
        check(23'(irq), 23'h0);
        // One mask bit open, then its own flag cleared
        for (int e = 0; e < 23; e++) begin
            loc = ev_loc(e);
            i_host.wr_reg(loc[10:3], full(loc[10:3]) ^ (8'h01 << loc[2:0]));
            check(23'(irq), 23'h1);
            clr = 23'(1) << e;
            tick(1);
            clr = '0;
            check(23'(irq), 23'h0);
            i_host.wr_reg(loc[10:3], full(loc[10:3]));
        end
        check(flag, 23'h0);
        end_sim();
    end
    // Cycle ceiling against a hang
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            end_sim();
        end
    end
endmodule : tb
